// >>> hw/rx_sync_pkg.sv
// constants and state layout of the receiver global sync and interrupt block
// Behaviour
// R1 - channel enables power channels, reset all off
// R2 - start sync only starts already enabled channels
// R3 - pin hop enable gates all pin hops
// R4 - pin start enable gates all pin starts
// R5 - first-only mode accepts just one event
// R6 - edge select: rising edge, else high level
// R7 - per-pin enables; channels choose their pin
// R8 - soft hop enable hops selected channels
// R9 - soft start enable starts selected channels
// R10 - soft select bits pick channels for soft sync
// R11 - host writes reserved word as 0x600
// R12 - interrupt flags are read-only to writes
// R13 - gain word change sets flag when enabled
// R14 - signature load sets flag when enabled
// R15 - power monitor expiry sets flag when enabled
// R16 - reserved flag and mask bits stay zero
// R17 - gain loop mask bits gate their flags
// R18 - signature mask bits gate their flags
// R19 - power monitor mask bit gates its flag
// R20 - monitor period counted in input clock cycles
// R21 - interrupt while any flag; clear-register clears
package rx_sync_pkg;
  localparam int unsigned NUM_CH      = 6;
  localparam int unsigned NUM_PIN     = 4;
  localparam int unsigned RSSI_W      = 12;
  localparam int unsigned PM_W        = 24;
  localparam int unsigned RSVD_W      = 11;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned DATA_W      = 16;
  // register indices on the register port
  localparam logic [2:0]  IDX_CH_EN   = 3'h0;
  localparam logic [2:0]  IDX_PIN     = 3'h1;
  localparam logic [2:0]  IDX_SOFT    = 3'h2;
  localparam logic [2:0]  IDX_RSVD    = 3'h3;
  localparam logic [2:0]  IDX_FLAGS   = 3'h4;
  localparam logic [2:0]  IDX_MASK    = 3'h5;
  localparam logic [2:0]  IDX_CLEAR   = 3'h6;
  // field positions
  localparam int unsigned PIN_HOP_EN  = 7;
  localparam int unsigned PIN_STRT_EN = 6;
  localparam int unsigned FIRST_ONLY  = 5;
  localparam int unsigned EDGE_SEL    = 4;
  localparam int unsigned SOFT_HOP    = 7;
  localparam int unsigned SOFT_STRT   = 6;
  localparam int unsigned FLAG_RSSI   = 10;
  localparam int unsigned FLAG_SIG    = 4;
  localparam int unsigned FLAG_PM     = 2;
  localparam logic [15:0] FLAG_VALID  = 16'hFFF4;
  localparam logic [10:0] RSVD_RST    = 11'h000;
  localparam logic [23:0] PM_ONE      = 24'h000001;

  typedef struct packed {
    logic [5:0]                ch_en;
    logic [7:0]                pin_cfg;
    logic [7:0]                soft_cfg;
    logic [10:0]               rsvd;
    logic [15:0]               flags;
    logic [15:0]               mask;
    logic [3:0]                s1;
    logic [3:0]                s2;
    logic [3:0]                s3;
    logic                      first_done;
    logic [23:0]               pm_cnt;
    logic [5:0][11:0]          rssi_prev;
    logic [15:0]               rdata;
    logic [5:0]                start;
    logic [5:0]                hop;
    logic                      irq;
  } state_t;
endpackage

// >>> hw/receiver_global_sync_irq_ctrl.sv
// channel enables, pin/soft sync distribution and interrupt flags
`timescale 1ns/1ps
module receiver_global_sync_irq_ctrl (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [2:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  output logic      [15:0] O_RDATA,
  input  wire logic [3:0]  I_SYNC_PIN,
  input  wire logic [5:0]  I_PIN_SYNC_MODE,
  input  wire logic [11:0] I_START_PIN_SEL,
  input  wire logic [11:0] I_HOP_PIN_SEL,
  input  wire logic [5:0]  I_RSSI_UPD,
  input  wire logic [71:0] I_RSSI_WORD,
  input  wire logic [5:0]  I_SIG_LOAD,
  input  wire logic [5:0]  I_SIG_MODE,
  input  wire logic        I_PM_ENABLE,
  input  wire logic [23:0] I_PM_PERIOD,
  output logic      [5:0]  O_CH_EN,
  output logic      [5:0]  O_START_SYNC,
  output logic      [5:0]  O_HOP_SYNC,
  output logic             O_IRQ
);
  rx_sync_pkg::state_t q;
  rx_sync_pkg::state_t d;
  logic [3:0]       pin_evt;
  logic [5:0]       start_req;
  logic [5:0]       hop_req;
  logic [5:0]       rssi_set;
  logic [5:0]       sig_set;
  logic [5:0][11:0] rssi_next;
  logic             soft_wr;
  logic             blocked;
  logic             pm_hit;

  assign soft_wr = I_WR && (I_ADDR == rx_sync_pkg::IDX_SOFT);
  // an accepted event locks out all later ones while first-only is set
  assign blocked = q.pin_cfg[rx_sync_pkg::FIRST_ONLY] && q.first_done; // R5
  assign pm_hit  = I_PM_ENABLE && ((q.pm_cnt + rx_sync_pkg::PM_ONE) >= I_PM_PERIOD); // R20

  // only the second and third sync stages are looked at
  for (genvar p = 0; p < rx_sync_pkg::NUM_PIN; p++) begin : g_pin
    assign pin_evt[p] = q.pin_cfg[p] && // R7
                        (q.pin_cfg[rx_sync_pkg::EDGE_SEL] ? (q.s2[p] && !q.s3[p])
                                                          : q.s2[p]); // R6
  end

  for (genvar c = 0; c < rx_sync_pkg::NUM_CH; c++) begin : g_ch
    logic [11:0] word;
    logic        pin_start;
    logic        pin_hop;
    logic        soft_start;
    logic        soft_hop;
    assign word       = I_RSSI_WORD[c*12 +: 12];
    assign pin_start  = q.pin_cfg[rx_sync_pkg::PIN_STRT_EN] && I_PIN_SYNC_MODE[c] &&
                        pin_evt[I_START_PIN_SEL[c*2 +: 2]]; // R4
    assign pin_hop    = q.pin_cfg[rx_sync_pkg::PIN_HOP_EN] && I_PIN_SYNC_MODE[c] &&
                        pin_evt[I_HOP_PIN_SEL[c*2 +: 2]]; // R3
    assign soft_start = soft_wr && I_WDATA[rx_sync_pkg::SOFT_STRT] && I_WDATA[c]; // R9 R10
    assign soft_hop   = soft_wr && I_WDATA[rx_sync_pkg::SOFT_HOP] && I_WDATA[c]; // R8 R10
    // a start on a disabled channel is dropped, not deferred
    assign start_req[c] = q.ch_en[c] && (pin_start || soft_start); // R2
    assign hop_req[c]   = pin_hop || soft_hop;
    assign rssi_set[c]  = I_RSSI_UPD[c] && (word != q.rssi_prev[c]) &&
                          q.mask[rx_sync_pkg::FLAG_RSSI + c]; // R13 R17
    assign sig_set[c]   = I_SIG_LOAD[c] && I_SIG_MODE[c] &&
                          q.mask[rx_sync_pkg::FLAG_SIG + c]; // R14 R18
    assign rssi_next[c] = I_RSSI_UPD[c] ? word : q.rssi_prev[c];
  end

  always_comb begin
    logic [15:0] set_v;
    logic [15:0] clr_v;
    d          = q;
    set_v      = '0;
    clr_v      = '0;
    d.s1       = I_SYNC_PIN;
    d.s2       = q.s1;
    d.s3       = q.s2;
    d.rssi_prev = rssi_next;
    d.start    = blocked ? 6'h00 : start_req; // R5
    d.hop      = blocked ? 6'h00 : hop_req; // R5
    if (!q.pin_cfg[rx_sync_pkg::FIRST_ONLY]) begin
      d.first_done = 1'b0;
    end else if ((|start_req) || (|hop_req)) begin
      d.first_done = 1'b1;
    end
    // power monitor period timer in input port clock cycles
    if (!I_PM_ENABLE || pm_hit) begin
      d.pm_cnt = '0; // R20
    end else begin
      d.pm_cnt = q.pm_cnt + rx_sync_pkg::PM_ONE;
    end
    if (I_WR) begin
      case (I_ADDR)
        rx_sync_pkg::IDX_CH_EN: begin
          d.ch_en = I_WDATA[5:0]; // R1
        end
        rx_sync_pkg::IDX_PIN: begin
          d.pin_cfg = I_WDATA[7:0];
        end
        rx_sync_pkg::IDX_SOFT: begin
          d.soft_cfg = I_WDATA[7:0];
        end
        rx_sync_pkg::IDX_RSVD: begin
          d.rsvd = I_WDATA[10:0];
        end
        rx_sync_pkg::IDX_MASK: begin
          d.mask = I_WDATA & rx_sync_pkg::FLAG_VALID; // R16
        end
        rx_sync_pkg::IDX_CLEAR: begin
          clr_v = I_WDATA; // R21
        end
        default: begin
          // flag index and unused indices ignore writes
          clr_v = '0; // R12
        end
      endcase
    end
    set_v[rx_sync_pkg::FLAG_RSSI +: 6] = rssi_set;
    set_v[rx_sync_pkg::FLAG_SIG +: 6]  = sig_set;
    set_v[rx_sync_pkg::FLAG_PM]        = pm_hit && q.mask[rx_sync_pkg::FLAG_PM]; // R15 R19
    // set wins over a clear in the same cycle
    d.flags = ((q.flags & ~clr_v) | set_v) & rx_sync_pkg::FLAG_VALID;
    d.irq   = |d.flags; // R21
    if (I_RD) begin
      case (I_ADDR)
        rx_sync_pkg::IDX_CH_EN: d.rdata = {10'h000, q.ch_en};
        rx_sync_pkg::IDX_PIN:   d.rdata = {8'h00, q.pin_cfg};
        rx_sync_pkg::IDX_SOFT:  d.rdata = {8'h00, q.soft_cfg};
        rx_sync_pkg::IDX_RSVD:  d.rdata = {5'h00, q.rsvd};
        rx_sync_pkg::IDX_FLAGS: d.rdata = q.flags;
        rx_sync_pkg::IDX_MASK:  d.rdata = q.mask;
        default:                d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      q <= '0; // R1
    end else begin
      q <= d;
    end
  end

  assign O_RDATA      = q.rdata;
  assign O_CH_EN      = q.ch_en;
  assign O_START_SYNC = q.start;
  assign O_HOP_SYNC   = q.hop;
  assign O_IRQ        = q.irq;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  property p_ch_en_write;
    I_WR && (I_ADDR == rx_sync_pkg::IDX_CH_EN) |=> O_CH_EN == $past(I_WDATA[5:0]);
  endproperty
  a_ch_en_write: assert property (p_ch_en_write) else $error("channel enable not written"); // R1

  property p_start_needs_en;
    ##1 ((O_START_SYNC & ~$past(q.ch_en)) == 6'h00);
  endproperty
  a_start_needs_en: assert property (p_start_needs_en) else $error("start on disabled channel"); // R2

  property p_pin_hop_gate;
    !q.pin_cfg[rx_sync_pkg::PIN_HOP_EN] && !soft_wr |=> O_HOP_SYNC == 6'h00;
  endproperty
  a_pin_hop_gate: assert property (p_pin_hop_gate) else $error("pin hop while gated"); // R3

  property p_pin_start_gate;
    !q.pin_cfg[rx_sync_pkg::PIN_STRT_EN] && !soft_wr |=> O_START_SYNC == 6'h00;
  endproperty
  a_pin_start_gate: assert property (p_pin_start_gate) else $error("pin start while gated"); // R4

  property p_first_only;
    q.pin_cfg[rx_sync_pkg::FIRST_ONLY] && q.first_done |=> (O_START_SYNC | O_HOP_SYNC) == 6'h00;
  endproperty
  a_first_only: assert property (p_first_only) else $error("second sync accepted"); // R5

  property p_edge_mode;
    q.pin_cfg[rx_sync_pkg::EDGE_SEL] && (q.s2 == q.s3) && !soft_wr
      |=> (O_START_SYNC | O_HOP_SYNC) == 6'h00;
  endproperty
  a_edge_mode: assert property (p_edge_mode) else $error("sync without edge"); // R6

  property p_pins_off;
    (q.pin_cfg[3:0] == 4'h0) && !soft_wr |=> (O_START_SYNC | O_HOP_SYNC) == 6'h00;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("sync from disabled pin"); // R7

  property p_soft_start;
    soft_wr && I_WDATA[rx_sync_pkg::SOFT_STRT] && !blocked
      |=> (O_START_SYNC & $past(I_WDATA[5:0] & q.ch_en)) == $past(I_WDATA[5:0] & q.ch_en);
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft start missed"); // R9

  property p_flags_ro;
    I_WR && (I_ADDR == rx_sync_pkg::IDX_FLAGS) |=> ($past(q.flags) & ~q.flags) == 16'h0000;
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flag write changed flags"); // R12

  property p_rssi_gate;
    ##1 (((q.flags & ~$past(q.flags) & ~$past(q.mask)) & 16'hFC00) == 16'h0000);
  endproperty
  a_rssi_gate: assert property (p_rssi_gate) else $error("unmasked gain flag set"); // R17

  property p_pm_gate;
    $rose(q.flags[rx_sync_pkg::FLAG_PM]) |-> $past(q.mask[rx_sync_pkg::FLAG_PM] && pm_hit);
  endproperty
  a_pm_gate: assert property (p_pm_gate) else $error("power flag without cause"); // R15

  property p_rsvd_zero;
    ((q.mask | q.flags) & ~rx_sync_pkg::FLAG_VALID) == 16'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // R16

  property p_irq;
    O_IRQ == (q.flags != 16'h0000);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not match flags"); // R21

  property p_soft_hop;
    soft_wr && I_WDATA[rx_sync_pkg::SOFT_HOP] && !blocked
      |=> (O_HOP_SYNC & $past(I_WDATA[5:0])) == $past(I_WDATA[5:0]);
  endproperty
  a_soft_hop: assert property (p_soft_hop) else $error("soft hop missed"); // R8

  property p_soft_sel;
    soft_wr && (q.pin_cfg[3:0] == 4'h0)
      |=> ((O_START_SYNC | O_HOP_SYNC) & ~$past(I_WDATA[5:0])) == 6'h00;
  endproperty
  a_soft_sel: assert property (p_soft_sel) else $error("sync on unselected channel"); // R10

  property p_soft_off;
    soft_wr && !I_WDATA[rx_sync_pkg::SOFT_HOP] && !I_WDATA[rx_sync_pkg::SOFT_STRT] &&
      (q.pin_cfg[3:0] == 4'h0) |=> (O_START_SYNC | O_HOP_SYNC) == 6'h00;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("soft sync while disabled"); // R8 R9

  // a repeated gain word must not raise the flag
  property p_rssi_change;
    $rose(q.flags[rx_sync_pkg::FLAG_RSSI])
      |-> $past(I_RSSI_UPD[0] && (I_RSSI_WORD[11:0] != q.rssi_prev[0]));
  endproperty
  a_rssi_change: assert property (p_rssi_change) else $error("gain flag without new word"); // R13

  property p_sig_gate;
    ##1 (((q.flags & ~$past(q.flags) & ~$past(q.mask)) & 16'h03F0) == 16'h0000);
  endproperty
  a_sig_gate: assert property (p_sig_gate) else $error("unmasked signature flag set"); // R18

  property p_sig_mode;
    $rose(q.flags[rx_sync_pkg::FLAG_SIG]) |-> $past(I_SIG_LOAD[0] && I_SIG_MODE[0]);
  endproperty
  a_sig_mode: assert property (p_sig_mode) else $error("signature flag without load"); // R14

  property p_pm_mask;
    !q.mask[rx_sync_pkg::FLAG_PM] && !q.flags[rx_sync_pkg::FLAG_PM] |=> !q.flags[rx_sync_pkg::FLAG_PM];
  endproperty
  a_pm_mask: assert property (p_pm_mask) else $error("power flag while masked"); // R19

  // the timer advances by one on every enabled cycle short of expiry
  property p_pm_count;
    I_PM_ENABLE && !pm_hit |=> q.pm_cnt == ($past(q.pm_cnt) + rx_sync_pkg::PM_ONE);
  endproperty
  a_pm_count: assert property (p_pm_count) else $error("power timer skipped"); // R20

  property p_pm_idle;
    !I_PM_ENABLE |=> q.pm_cnt == 24'h000000;
  endproperty
  a_pm_idle: assert property (p_pm_idle) else $error("power timer ran while off"); // R20

  property p_clear_all;
    I_WR && (I_ADDR == rx_sync_pkg::IDX_CLEAR) && (I_WDATA == 16'hFFFF) && !pm_hit &&
      (rssi_set == 6'h00) && (sig_set == 6'h00) |=> q.flags == 16'h0000;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("flags not cleared"); // R21

  // a clear in the same cycle must not swallow a new event
  property p_set_wins;
    rssi_set[0] |=> q.flags[rx_sync_pkg::FLAG_RSSI];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("gain event lost"); // R13 R21

  property p_flags_read;
    I_RD && (I_ADDR == rx_sync_pkg::IDX_FLAGS) |=> O_RDATA == $past(q.flags);
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read mismatch"); // R12

  property p_level_mode;
    !q.pin_cfg[rx_sync_pkg::EDGE_SEL] && q.pin_cfg[0] && q.pin_cfg[rx_sync_pkg::PIN_STRT_EN] &&
      q.s2[0] && I_PIN_SYNC_MODE[0] && (I_START_PIN_SEL[1:0] == 2'h0) && q.ch_en[0] && !blocked
      |=> O_START_SYNC[0];
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("level sync missed"); // R6

  // the lock must engage on the very first accepted event
  property p_first_lock;
    q.pin_cfg[rx_sync_pkg::FIRST_ONLY] && ((|start_req) || (|hop_req)) |=> q.first_done;
  endproperty
  a_first_lock: assert property (p_first_lock) else $error("first-only lock missed"); // R5
endmodule

// >>> tb/host_model.sv
// host side of the register port: one-cycle write and read requests
`timescale 1ns/1ps
module host_model (
  input  wire logic        i_clock,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [2:0]       o_addr,
  output logic [15:0]      o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 3'h0;
    o_wdata = 16'h0000;
  end
  // request held over exactly one taking edge, so each call is one access
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_clock);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the global sync and interrupt block
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  pin = 4'h0;
  logic [5:0]  mode = 6'h3F;
  logic [5:0]  smode = 6'h3F;
  logic [5:0]  upd = 6'h00;
  logic [5:0]  sld = 6'h00;
  logic [71:0] word = 72'h0;
  logic        pm_en = 1'b0;
  logic [23:0] per = 24'h000005;
  logic        wr, rd, irq;
  logic [2:0]  addr;
  logic [15:0] wd, rdat, v;
  logic [5:0]  ch_en, st, hop;
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;
  int          ns, nh;
  always #5 clk = ~clk;
  host_model host (.i_clock(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wd));
  receiver_global_sync_irq_ctrl uut (.I_CLOCK(clk), .I_RST(rst), .I_WR(wr), .I_RD(rd),
    .I_ADDR(addr), .I_WDATA(wd), .O_RDATA(rdat), .I_SYNC_PIN(pin), .I_PIN_SYNC_MODE(mode),
    .I_START_PIN_SEL(12'h000), .I_HOP_PIN_SEL(12'h000), .I_RSSI_UPD(upd), .I_RSSI_WORD(word),
    .I_SIG_LOAD(sld), .I_SIG_MODE(smode), .I_PM_ENABLE(pm_en), .I_PM_PERIOD(per),
    .O_CH_EN(ch_en), .O_START_SYNC(st), .O_HOP_SYNC(hop), .O_IRQ(irq));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask
  task automatic wrap_up;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // pin 0 high for n cycles; pulses on channel 0 counted over a fixed window
  task automatic pin_run(input logic [7:0] cfg, input int n);
    host.wr(rx_sync_pkg::IDX_PIN, {8'h00, cfg});
    ns = 0;
    nh = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      pin <= {3'b000, i < n};
      #1;
      ns += (st[0] === 1'b1);
      nh += (hop[0] === 1'b1);
    end
  endtask
  task automatic ev(input logic [5:0] u, input logic [5:0] s, input logic [11:0] w);
    @(posedge clk);
    upd <= u;
    sld <= s;
    word <= {6{w}};
    @(posedge clk);
    upd <= 6'h00;
    sld <= 6'h00;
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({ch_en, irq}, 7'h00);
    rchk(rx_sync_pkg::IDX_CH_EN, 16'h0000);
    host.wr(rx_sync_pkg::IDX_CH_EN, 16'h0001);
    chk(ch_en, 6'h01);
    host.wr(rx_sync_pkg::IDX_RSVD, 16'h0600);
    rchk(rx_sync_pkg::IDX_RSVD, 16'h0600);
    host.wr(rx_sync_pkg::IDX_SOFT, 16'h00C3);
    chk({st, hop}, 12'h043);
    @(posedge clk);
    #1;
    chk({st, hop}, 12'h000);
    host.wr(rx_sync_pkg::IDX_SOFT, 16'h0003);
    chk({st, hop}, 12'h000);
    host.wr(rx_sync_pkg::IDX_SOFT, 16'h0082);
    chk({st, hop}, 12'h002);
    host.wr(rx_sync_pkg::IDX_CH_EN, 16'h003F);
    host.wr(rx_sync_pkg::IDX_PIN, 16'h0020);
    host.wr(rx_sync_pkg::IDX_SOFT, 16'h0060);
    chk({st, hop}, 12'h800);
    host.wr(rx_sync_pkg::IDX_SOFT, 16'h0060);
    chk({st, hop}, 12'h000);
    pin_run(8'h51, 3);
    chk({ns[7:0], nh[7:0]}, 16'h0100);
    pin_run(8'h41, 3);
    chk({ns[7:0], nh[7:0]}, 16'h0300);
    pin_run(8'h50, 3);
    chk({ns[7:0], nh[7:0]}, 16'h0000);
    pin_run(8'h91, 3);
    chk({ns[7:0], nh[7:0]}, 16'h0001);
    host.wr(rx_sync_pkg::IDX_MASK, 16'hFFFF);
    rchk(rx_sync_pkg::IDX_MASK, 16'hFFF4);
    host.wr(rx_sync_pkg::IDX_MASK, 16'h0400);
    host.wr(rx_sync_pkg::IDX_CLEAR, 16'hFFFF);
    ev(6'h01, 6'h00, 12'h123);
    chk(irq, 1'b1);
    host.wr(rx_sync_pkg::IDX_FLAGS, 16'h0000);
    rchk(rx_sync_pkg::IDX_FLAGS, 16'h0400);
    host.wr(rx_sync_pkg::IDX_CLEAR, 16'hFFFF);
    chk(irq, 1'b0);
    ev(6'h01, 6'h00, 12'h123);
    ev(6'h02, 6'h00, 12'h456);
    rchk(rx_sync_pkg::IDX_FLAGS, 16'h0000);
    host.wr(rx_sync_pkg::IDX_MASK, 16'h0010);
    ev(6'h00, 6'h03, 12'h456);
    rchk(rx_sync_pkg::IDX_FLAGS, 16'h0010);
    host.wr(rx_sync_pkg::IDX_CLEAR, 16'hFFFF);
    host.wr(rx_sync_pkg::IDX_MASK, 16'h0004);
    @(posedge clk);
    pm_en <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    rchk(rx_sync_pkg::IDX_FLAGS, 16'h0004);
    host.wr(rx_sync_pkg::IDX_MASK, 16'h0000);
    host.wr(rx_sync_pkg::IDX_CLEAR, 16'hFFFF);
    repeat (12) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wrap_up;
  end
endmodule
